// file: logic/dsr_regs.svh
`ifndef DSR_REGS_SVH
`define DSR_REGS_SVH

// Register indices; the byte address is four times the index.
`define DSR_IDX_TILE_CELL_OSC   8'h07
`define DSR_IDX_TILE_WIRE_OSC   8'h08
`define DSR_IDX_PERIPH_CELL_OSC 8'h09
`define DSR_IDX_PERIPH_WIRE_OSC 8'h0a
`define DSR_IDX_MEMORY_SIZE     8'h0c
`define DSR_IDX_SAVED_STATUS    8'h10
`define DSR_IDX_SAVED_PC        8'h11
`define DSR_IDX_SAVED_STACK_PTR 8'h12
`define DSR_IDX_READ_THREAD_SEL 8'h13
`define DSR_IDX_READ_REG_SEL    8'h14
`define DSR_IDX_IRQ_CAUSE       8'h15
`define DSR_IDX_EVENT_STATUS    8'h3c
`define DSR_IDX_EVENT_MASK      8'h3d

// Saved status word bit positions.
`define DSR_STW_ASID_BIT        10
`define DSR_STW_NEXT_ISSUE_BIT  9
`define DSR_STW_ISSUE_MODE_BIT  8
`define DSR_STW_FAST_BIT        7
`define DSR_STW_PAUSED_BIT      6
`define DSR_STW_KERNEL_BIT      4
`define DSR_STW_IN_IRQ_BIT      3
`define DSR_STW_EV_SEQ_BIT      2
`define DSR_STW_IRQ_EN_BIT      1
`define DSR_STW_EV_EN_BIT       0
`define DSR_STW_MSB             10
`define DSR_STW_CAPT_MASK       11'h7df
`define DSR_STW_WRITE_MASK      11'h6df

// Debug interrupt cause field layout and codes.
`define DSR_CAUSE_LSB           0
`define DSR_CAUSE_MSB           2
`define DSR_THREAD_LSB          8
`define DSR_THREAD_MSB          15
`define DSR_BP_IDX_LSB          16
`define DSR_BP_IDX_MSB          17
`define DSR_CAUSE_HOST          3'h1
`define DSR_CAUSE_DEBUG_CALL    3'h2
`define DSR_CAUSE_IBREAK        3'h3
`define DSR_CAUSE_DWATCH        3'h4
`define DSR_CAUSE_RWATCH        3'h5

// Field widths and positions of narrow registers.
`define DSR_OSC_MSB             15
`define DSR_THREAD_SEL_MSB      7
`define DSR_REG_SEL_MSB         4
`define DSR_MEM_SIZE_LSB        2

// Event status bits.
`define DSR_EV_CAPTURE_BIT      0
`define DSR_EV_REFUSED_BIT      1

// Reset values.
`define DSR_RST_WORD            32'h0000_0000
`define DSR_RST_STW             11'h000
`define DSR_RST_CAUSE           3'h0
`define DSR_RST_EVENTS          2'h0
`define DSR_RST_OSC             16'h0000

`endif

// file: logic/dsr_pkg.sv
package dsr_pkg;

    typedef struct packed {
        logic [15:0] count;
    } dsr_osc_t;

    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic [10:0] status_word;
        logic [31:0] pc;
        logic [31:0] sp;
        logic [7:0]  thread_sel;
        logic [4:0]  reg_sel;
        logic [2:0]  cause;
        logic [1:0]  bp_idx;
        logic [7:0]  cause_thread;
        logic [1:0]  ev_status;
        logic [1:0]  ev_mask;
        logic        irq;
    } dsr_state_t;

endpackage : dsr_pkg

// file: logic/dsr_osc_count.sv
`timescale 1ns/10ps
`include "dsr_regs.svh"

module dsr_osc_count (
    input  wire logic        hclk,
    input  wire logic        osc_por_n,
    input  wire logic        tick,
    output logic [15:0]      count
);

    dsr_pkg::dsr_osc_t st;
    dsr_pkg::dsr_osc_t next_st;

    always_comb begin
        next_st = st;
        if (tick) begin
            next_st.count = st.count + 16'h0001;
        end
    end

    // Only the power-on reset clears the count; system reset leaves it alone.
    always_ff @(posedge hclk or negedge osc_por_n) begin
        if (!osc_por_n) begin
            st.count <= `DSR_RST_OSC;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;

endmodule : dsr_osc_count

// file: logic/dsr_bank.sv
`timescale 1ns/10ps
`include "dsr_regs.svh"

// Overview of operation
// - Four read-only 16-bit oscillator count registers.
// - Oscillator counts survive system reset unchanged.
// - Read-only memory size register, low bits zero.
// - Debug entry captures saved status word.
// - Status word mode and enable flag bits.
// - Bit 8 current issue mode, bit 9 next.
// - Debug entry captures saved program counter.
// - Debug entry captures saved stack pointer.
// - Eight-bit thread select for debug register read.
// - Five-bit register select for debug register read.
// - Three-bit debug cause field, resets to zero.
// - Lowest fired breakpoint index, zero otherwise.
// - Causing thread number, zero for host.

module dsr_bank #(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0001_0000
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        osc_por_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [3:0]  osc_tick,
    input  wire logic        debug_mode,
    input  wire logic        debug_enter,
    input  wire logic [10:0] status_word_in,
    input  wire logic [31:0] pc_in,
    input  wire logic [31:0] sp_in,
    input  wire logic [2:0]  cause_in,
    input  wire logic [3:0]  bp_hits_in,
    input  wire logic [7:0]  thread_in,
    output logic [7:0]       read_thread_sel,
    output logic [4:0]       read_reg_sel,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////

    dsr_pkg::dsr_state_t st;
    dsr_pkg::dsr_state_t next_st;
    logic [3:0][15:0]    osc_count;

    ////////////////////////////////////////////////////////////////////////////////

    // One free count per oscillator, held across system reset.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_osc
            dsr_osc_count u_osc (
                .hclk      (hclk),
                .osc_por_n (osc_por_n),
                .tick      (osc_tick[gi]),
                .count     (osc_count[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    // Lowest set index among the fired breakpoints or watchpoints.
    function automatic logic [1:0] lowest_hit(input logic [3:0] hits);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (hits[i]) begin
                idx = i[1:0];
            end
        end
        return idx;
    endfunction : lowest_hit

    // True for registers whose fields only debug mode may change.
    function automatic logic is_debug_reg(input logic [7:0] idx);
        logic hit;
        hit = 1'b0;
        if (idx == `DSR_IDX_SAVED_STATUS) begin
            hit = 1'b1;
        end else if (idx == `DSR_IDX_SAVED_PC) begin
            hit = 1'b1;
        end else if (idx == `DSR_IDX_SAVED_STACK_PTR) begin
            hit = 1'b1;
        end else if (idx == `DSR_IDX_READ_THREAD_SEL) begin
            hit = 1'b1;
        end else if (idx == `DSR_IDX_READ_REG_SEL) begin
            hit = 1'b1;
        end else if (idx == `DSR_IDX_IRQ_CAUSE) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : is_debug_reg

    // Read value of one register; reserved bits and unmapped words are zero.
    function automatic logic [31:0] read_word(
        input logic [7:0]          idx,
        input dsr_pkg::dsr_state_t s,
        input logic [3:0][15:0]    osc
    );
        logic [31:0] w;
        w = `DSR_RST_WORD;
        if (idx == `DSR_IDX_TILE_CELL_OSC) begin
            w[`DSR_OSC_MSB:0] = osc[0];
        end else if (idx == `DSR_IDX_TILE_WIRE_OSC) begin
            w[`DSR_OSC_MSB:0] = osc[1];
        end else if (idx == `DSR_IDX_PERIPH_CELL_OSC) begin
            w[`DSR_OSC_MSB:0] = osc[2];
        end else if (idx == `DSR_IDX_PERIPH_WIRE_OSC) begin
            w[`DSR_OSC_MSB:0] = osc[3];
        end else if (idx == `DSR_IDX_MEMORY_SIZE) begin
            w[31:`DSR_MEM_SIZE_LSB] = MEM_SIZE_BYTES[31:`DSR_MEM_SIZE_LSB];
        end else if (idx == `DSR_IDX_SAVED_STATUS) begin
            w[`DSR_STW_MSB:0] = s.status_word;
        end else if (idx == `DSR_IDX_SAVED_PC) begin
            w = s.pc;
        end else if (idx == `DSR_IDX_SAVED_STACK_PTR) begin
            w = s.sp;
        end else if (idx == `DSR_IDX_READ_THREAD_SEL) begin
            w[`DSR_THREAD_SEL_MSB:0] = s.thread_sel;
        end else if (idx == `DSR_IDX_READ_REG_SEL) begin
            w[`DSR_REG_SEL_MSB:0] = s.reg_sel;
        end else if (idx == `DSR_IDX_IRQ_CAUSE) begin
            w[`DSR_CAUSE_MSB:`DSR_CAUSE_LSB]   = s.cause;
            w[`DSR_THREAD_MSB:`DSR_THREAD_LSB] = s.cause_thread;
            w[`DSR_BP_IDX_MSB:`DSR_BP_IDX_LSB] = s.bp_idx;
        end else if (idx == `DSR_IDX_EVENT_STATUS) begin
            w[1:0] = s.ev_status;
        end else if (idx == `DSR_IDX_EVENT_MASK) begin
            w[1:0] = s.ev_mask;
        end
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////////////

    logic       addr_phase;
    logic       addr_ok;
    logic [7:0] addr_idx;
    logic [1:0] set_ev;
    logic       clear_ev;

    assign addr_phase = hsel && hready && htrans[1];
    assign addr_ok    = (haddr[31:10] == 22'h00_0000);
    assign addr_idx   = haddr[9:2];

    always_comb begin
        next_st  = st;
        set_ev   = `DSR_RST_EVENTS;
        clear_ev = 1'b0;

        // Data phase of a write: apply hwdata to the register index latched in the address phase.
        if (st.wr_pend) begin
            if (st.wr_idx == `DSR_IDX_EVENT_MASK) begin
                next_st.ev_mask = hwdata[1:0];
            end else if (is_debug_reg(st.wr_idx) && !debug_mode) begin
                set_ev[`DSR_EV_REFUSED_BIT] = 1'b1;
            end else if (st.wr_idx == `DSR_IDX_SAVED_STATUS) begin
                next_st.status_word = (hwdata[`DSR_STW_MSB:0] & `DSR_STW_WRITE_MASK)
                                    | (st.status_word & ~`DSR_STW_WRITE_MASK);
            end else if (st.wr_idx == `DSR_IDX_SAVED_PC) begin
                next_st.pc = hwdata;
            end else if (st.wr_idx == `DSR_IDX_SAVED_STACK_PTR) begin
                next_st.sp = hwdata;
            end else if (st.wr_idx == `DSR_IDX_READ_THREAD_SEL) begin
                next_st.thread_sel = hwdata[`DSR_THREAD_SEL_MSB:0];
            end else if (st.wr_idx == `DSR_IDX_READ_REG_SEL) begin
                next_st.reg_sel = hwdata[`DSR_REG_SEL_MSB:0];
            end else if (st.wr_idx == `DSR_IDX_IRQ_CAUSE) begin
                next_st.cause        = hwdata[`DSR_CAUSE_MSB:`DSR_CAUSE_LSB];
                next_st.cause_thread = hwdata[`DSR_THREAD_MSB:`DSR_THREAD_LSB];
                next_st.bp_idx       = hwdata[`DSR_BP_IDX_MSB:`DSR_BP_IDX_LSB];
            end
        end

        // Debugger entry overrides a software write in the same cycle.
        if (debug_enter) begin
            next_st.status_word = status_word_in & `DSR_STW_CAPT_MASK;
            next_st.pc  = pc_in;
            next_st.sp  = sp_in;
            next_st.cause = cause_in;
            if (cause_in == `DSR_CAUSE_HOST) begin
                next_st.cause_thread = 8'h00;
            end else begin
                next_st.cause_thread = thread_in;
            end
            if (cause_in == `DSR_CAUSE_HOST || cause_in == `DSR_CAUSE_DEBUG_CALL) begin
                next_st.bp_idx = 2'h0;
            end else begin
                next_st.bp_idx = lowest_hit(bp_hits_in);
            end
            set_ev[`DSR_EV_CAPTURE_BIT] = 1'b1;
        end

        // Address phase: writes wait for their data, reads answer at once.
        next_st.wr_pend = 1'b0;
        if (addr_phase) begin
            if (hwrite) begin
                next_st.wr_pend = addr_ok;
                next_st.wr_idx  = addr_idx;
            end else if (addr_ok) begin
                next_st.hrdata = read_word(addr_idx, next_st, osc_count);
                clear_ev       = (addr_idx == `DSR_IDX_EVENT_STATUS);
            end else begin
                next_st.hrdata = `DSR_RST_WORD;
            end
        end

        // Read of the status register clears it; a new event still wins.
        if (clear_ev) begin
            next_st.ev_status = set_ev;
        end else begin
            next_st.ev_status = st.ev_status | set_ev;
        end

        next_st.irq       = |(next_st.ev_status & next_st.ev_mask);
        next_st.hreadyout = 1'b1;
        next_st.hresp     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st.hreadyout    <= 1'b1;
            st.hresp        <= 1'b0;
            st.hrdata       <= `DSR_RST_WORD;
            st.wr_pend      <= 1'b0;
            st.wr_idx       <= 8'h00;
            st.status_word  <= `DSR_RST_STW;
            st.pc           <= `DSR_RST_WORD;
            st.sp           <= `DSR_RST_WORD;
            st.thread_sel   <= 8'h00;
            st.reg_sel      <= 5'h00;
            st.cause        <= `DSR_RST_CAUSE;
            st.bp_idx       <= 2'h0;
            st.cause_thread <= 8'h00;
            st.ev_status    <= `DSR_RST_EVENTS;
            st.ev_mask      <= `DSR_RST_EVENTS;
            st.irq          <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign hreadyout       = st.hreadyout;
    assign hresp           = st.hresp;
    assign hrdata          = st.hrdata;
    assign read_thread_sel = st.thread_sel;
    assign read_reg_sel    = st.reg_sel;
    assign irq             = st.irq;

endmodule : dsr_bank

// file: tb/dsr_bank_sva.sv
`timescale 1ns/10ps

module dsr_bank_sva #(
    parameter logic [31:0] MEM_SIZE_BYTES = 32'h0001_0000
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        debug_mode,
    input wire logic        debug_enter,
    input wire logic [7:0]  read_thread_sel,
    input wire logic [4:0]  read_reg_sel,
    input wire logic        irq
);
    logic       ap_w;
    logic       ap_r;
    logic [7:0] ap_i;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Marks the data phase of a mapped transfer and keeps its word index.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_w <= 1'b0;
            ap_r <= 1'b0;
            ap_i <= 8'h00;
        end else begin
            ap_w <= hsel & hready & htrans[1] & hwrite & (haddr[31:10] == 22'h0);
            ap_r <= hsel & hready & htrans[1] & !hwrite & (haddr[31:10] == 22'h0);
            ap_i <= haddr[9:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not ready and okay");
    AST_TSEL: assert property (ap_w && ap_i == 8'h13 && debug_mode |=> read_thread_sel == $past(hwdata[7:0]))
        else $error("thread select not written");
    AST_RSEL: assert property (ap_w && ap_i == 8'h14 && debug_mode |=> read_reg_sel == $past(hwdata[4:0]))
        else $error("register select not written");
    AST_HOLD: assert property (!(ap_w && ap_i == 8'h13 && debug_mode) |=> $stable(read_thread_sel))
        else $error("thread select changed without a debug write");
    AST_TSEL_RD: assert property (ap_r && ap_i == 8'h13 |-> hrdata == {24'h0, read_thread_sel})
        else $error("thread select read back wrong");
    AST_RSEL_RD: assert property (ap_r && ap_i == 8'h14 |-> hrdata == {27'h0, read_reg_sel})
        else $error("register select read back wrong");
    AST_MSIZE: assert property (ap_r && ap_i == 8'h0c |-> hrdata == {MEM_SIZE_BYTES[31:2], 2'b00})
        else $error("memory size read wrong");
    AST_RD_HOLD: assert property (!ap_r |-> $stable(hrdata))
        else $error("read data changed outside a read");
    AST_IRQ: assert property ($rose(irq) |-> $past(debug_enter) || $past(ap_w))
        else $error("interrupt rose without a cause");
endmodule : dsr_bank_sva

bind dsr_bank dsr_bank_sva #(.MEM_SIZE_BYTES(MEM_SIZE_BYTES)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .debug_mode(debug_mode), .debug_enter(debug_enter),
    .read_thread_sel(read_thread_sel), .read_reg_sel(read_reg_sel), .irq(irq));

// file: tb/tb.sv
`timescale 1ns/10ps

module tb;
    localparam logic [31:0] MSZ = 32'h0003_0007;
    logic hclk = 0, hresetn = 0, osc_por_n = 0, hsel = 0, hwrite = 0;
    logic debug_mode = 0, debug_enter = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = 0, hwdata = 0, pc_in = 0, sp_in = 0, hrdata;
    logic [1:0] htrans = 0;
    logic [3:0] osc_tick = 0, bp_hits_in = 0;
    logic [10:0] status_word_in = 0;
    logic [2:0] cause_in = 0;
    logic [7:0] thread_in = 0, read_thread_sel;
    logic [4:0] read_reg_sel;
    int err_total = 0;
    int num_checks = 0;

    always #20 hclk = ~hclk;

    dsr_bank #(.MEM_SIZE_BYTES(MSZ)) dut (
        .hclk(hclk), .hresetn(hresetn), .osc_por_n(osc_por_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .osc_tick(osc_tick),
        .debug_mode(debug_mode), .debug_enter(debug_enter), .status_word_in(status_word_in),
        .pc_in(pc_in), .sp_in(sp_in), .cause_in(cause_in), .bp_hits_in(bp_hits_in),
        .thread_in(thread_in), .read_thread_sel(read_thread_sel), .read_reg_sel(read_reg_sel),
        .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {22'h0, i, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, i, d, q);
    endtask : wr

    task automatic rd_chk(input string n, input logic [7:0] i, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, i, 32'h0, q);
        chk(n, q, e);
    endtask : rd_chk

    task automatic capture(input logic [2:0] c);
        debug_enter <= 1'b1;
        cause_in <= c;
        bp_hits_in <= 4'ha;
        thread_in <= 8'h5a;
        status_word_in <= 11'h7ff;
        pc_in <= 32'h1234_5678;
        sp_in <= 32'h8765_4321;
        @(posedge hclk);
        debug_enter <= 1'b0;
        @(posedge hclk);
    endtask : capture

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        for (int k = 0; k < 4; k++) rd_chk("osc", 8'(8'h07 + k), 32'h0);
        rd_chk("memsize", 8'h0c, 32'h0003_0004);
        rd_chk("cause", 8'h15, 32'h0);
        wr(8'h01, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'h01, 32'h0);
    endtask : t_reset

    task automatic t_osc();
        for (int k = 0; k < 4; k++) begin
            osc_tick <= 4'hf << k;
            @(posedge hclk);
        end
        osc_tick <= 4'h0;
        repeat (10) @(posedge hclk);
        wr(8'h07, 32'hFFFF_FFFF);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int k = 0; k < 4; k++) rd_chk("osc", 8'(8'h07 + k), 32'(k + 1));
    endtask : t_osc

    task automatic t_capture();
        for (int c = 1; c <= 5; c++) begin
            capture(c[2:0]);
            rd_chk("cause", 8'h15, {14'h0, (c > 2) ? 2'h1 : 2'h0, (c == 1) ? 8'h0 : 8'h5a, 5'h0, c[2:0]});
        end
        rd_chk("status", 8'h10, 32'h0000_07df);
        rd_chk("pc", 8'h11, 32'h1234_5678);
        rd_chk("sp", 8'h12, 32'h8765_4321);
    endtask : t_capture

    task automatic t_write();
        wr(8'h13, 32'hFFFF_FFFF);
        rd_chk("tsel", 8'h13, 32'h0);
        chk("tsel port", {24'h0, read_thread_sel}, 32'h0);
        debug_mode <= 1'b1;
        wr(8'h13, 32'hFFFF_FFFF);
        rd_chk("tsel", 8'h13, 32'h0000_00ff);
        chk("tsel port", {24'h0, read_thread_sel}, 32'h0000_00ff);
        wr(8'h14, 32'hFFFF_FFFF);
        rd_chk("rsel", 8'h14, 32'h0000_001f);
        chk("rsel port", {27'h0, read_reg_sel}, 32'h0000_001f);
        wr(8'h10, 32'h0);
        rd_chk("status", 8'h10, 32'h0000_0100);
        wr(8'h11, 32'h0bad_f00d);
        rd_chk("pc", 8'h11, 32'h0bad_f00d);
        debug_mode <= 1'b0;
    endtask : t_write

    task automatic t_irq();
        rd_chk("events", 8'h3c, 32'h3);
        rd_chk("events", 8'h3c, 32'h0);
        wr(8'h3d, 32'h1);
        capture(3'h1);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h1);
        rd_chk("events", 8'h3c, 32'h1);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(8'h3d, 32'h0);
        capture(3'h2);
        repeat (2) @(posedge hclk);
        chk("irq", {31'h0, irq}, 32'h0);
        rd_chk("events", 8'h3c, 32'h1);
    endtask : t_irq

    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        osc_por_n <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_osc();
        t_capture();
        t_write();
        t_irq();
        conclude();
    end
endmodule : tb
